//--- hdl/sses_sequencer.sv
`default_nettype none
`include "sses_map.svh"
// Functional notes
// RULE1 - No supplies: no-supply state, logic reset
// RULE2 - Enable pin low: disabled, all off
// RULE3 - Overtemperature: thermal hold, nothing charged
// RULE4 - Supply charge: only start-up source on
// RULE5 - Regulator charge: series regulator on
// RULE6 - Boost charge: only power-factor controller; code also keeps series regulator on
// RULE7 - Operational: both controllers run
// RULE8 - Restart trigger: restart, timer, IC charged
// RULE9 - Shutdown trigger: protection shutdown, all off
// RULE10 - Any supply present: source enable pullup
// RULE11 - Enable above both thresholds: both enabled
// RULE12 - Below both: pfc stops, bridge waits low-side
// RULE13 - Between thresholds: only half-bridge disabled
// RULE14 - Bridge disabled by pin: low-side held on
// RULE15 - External pulldown exceeds soft-start current
// RULE16 - Operate only after both supplies start
// RULE17 - Shutdown latched; cleared by reset paths
// RULE18 - Restart timer expiry repeats start-up
// RULE19 - Start-up order charge, regulator, boost, run
// RULE20 - Comparator inputs synchronised before use
module sses_sequencer (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Comparator results from the analogue front end
  input  wire sses_pkg::sses_cmp_t cmp_async,
  // Half-bridge phase and restart timer status
  input  wire logic               hb_low_phase,
  input  wire logic               restart_done,
  // Enables and state
  output var  sses_pkg::sses_ctl_t ctl,
  output var  sses_pkg::sses_state_t state
);

  // --------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------
  sses_pkg::sses_cmp_t c;
  logic [1:0]          st_sync;

  // RULE20 - comparators synchronised
  sses_sync #(.WIDTH(`SSES_NUM_INPUTS)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .d_async (cmp_async),
    .d_sync  (c)
  );

  // Timer and phase come from on-chip logic on this clock, no sync
  assign st_sync = {hb_low_phase, restart_done};

  // --------------------------------------------------------------------
  // Derived conditions
  // --------------------------------------------------------------------
  logic no_supply;
  logic en_off;
  logic uvp;

  // RULE1 - both supplies gone
  assign no_supply = !c.hv_present && !c.ic_present;
  // RULE2 - pin below pfc threshold means fully disabled
  assign en_off    = !c.en_pfc;
  assign uvp       = c.ic_uvp || c.reg_uvp;

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  sses_pkg::sses_state_t state_q, state_d;

  // Priority: supply, enable, shutdown latch, thermal, protection, sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      sses_pkg::SSES_SHUTDOWN: begin
        // RULE17 - latched, only three exits
        if (c.mains_reset) begin
          state_d = sses_pkg::SSES_IC_CHARGE;
        end
      end
      sses_pkg::SSES_RESTART: begin
        // RULE18 - timer expiry restarts sequence
        if (st_sync[0]) begin
          state_d = sses_pkg::SSES_IC_CHARGE;
        end
      end
      sses_pkg::SSES_THERMAL: begin
        if (!c.otp) begin
          state_d = sses_pkg::SSES_IC_CHARGE;
        end
      end
      sses_pkg::SSES_NO_SUPPLY,
      sses_pkg::SSES_DISABLED: begin
        state_d = sses_pkg::SSES_IC_CHARGE;
      end
      // RULE19 - ordered start-up
      sses_pkg::SSES_IC_CHARGE: begin
        if (c.ic_start) begin
          state_d = sses_pkg::SSES_REG_CHARGE;
        end
      end
      sses_pkg::SSES_REG_CHARGE: begin
        // RULE16 - both start levels reached
        if (c.ic_start && c.reg_start) begin
          state_d = sses_pkg::SSES_BOOST;
        end
      end
      sses_pkg::SSES_BOOST: begin
        // RULE11 - whole-IC threshold lets bridge start
        if (uvp) begin
          state_d = sses_pkg::SSES_IC_CHARGE;
        end else if (c.en_ic) begin
          state_d = sses_pkg::SSES_OPER;
        end
      end
      sses_pkg::SSES_OPER: begin
        // RULE13 - back to pfc only below whole-IC threshold
        if (uvp) begin
          state_d = sses_pkg::SSES_IC_CHARGE;
        end else if (!c.en_ic) begin
          state_d = sses_pkg::SSES_BOOST;
        end
      end
      default: begin
        state_d = sses_pkg::SSES_NO_SUPPLY;
      end
    endcase
    // Global overrides, highest last
    if (state_q != sses_pkg::SSES_SHUTDOWN) begin
      // RULE8 - restart-class trigger
      if (c.prot_restart && state_q != sses_pkg::SSES_RESTART) begin
        state_d = sses_pkg::SSES_RESTART;
      end
      // RULE9 - shutdown-class trigger
      if (c.prot_shutdown) begin
        state_d = sses_pkg::SSES_SHUTDOWN;
      end
      // RULE3 - thermal hold while overtemperature
      if (c.otp) begin
        state_d = sses_pkg::SSES_THERMAL;
      end
    end
    // RULE2 - pin low wins, also clears shutdown latch
    if (en_off) begin
      state_d = sses_pkg::SSES_DISABLED;
    end
    // RULE1 - supply loss resets everything
    if (no_supply) begin
      state_d = sses_pkg::SSES_NO_SUPPLY;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= sses_pkg::sses_state_t'(`SSES_STATE_RST);
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------
  // Half-bridge stop at low-side phase
  // --------------------------------------------------------------------
  logic hbc_run_q;
  logic hbc_want;

  assign hbc_want = (state_d == sses_pkg::SSES_OPER);

  // RULE12 - bridge finishes until low-side phase active
  always_ff @(posedge clk) begin
    if (rst) begin
      hbc_run_q <= 1'b0;
    end else if (hbc_want) begin
      hbc_run_q <= 1'b1;
    end else if (st_sync[1]) begin
      hbc_run_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Output register
  // --------------------------------------------------------------------
  sses_pkg::sses_ctl_t ctl_d;

  always_comb begin
    ctl_d = '0;
    // RULE10 - pullup while any supply present
    ctl_d.pullup_en = !no_supply;
    case (state_d)
      // RULE1 - logic held in reset
      sses_pkg::SSES_NO_SUPPLY: ctl_d.logic_rst = 1'b1;
      // RULE4 - only start-up source
      sses_pkg::SSES_IC_CHARGE: ctl_d.hv_source_en = 1'b1;
      // RULE5 - series regulator charges
      sses_pkg::SSES_REG_CHARGE: ctl_d.reg_en = 1'b1;
      // RULE6 - power-factor controller, series regulator kept on
      sses_pkg::SSES_BOOST: begin
        ctl_d.pfc_en = 1'b1;
        ctl_d.reg_en = 1'b1;
      end
      // RULE7 - both controllers
      sses_pkg::SSES_OPER: begin
        ctl_d.pfc_en = 1'b1;
        ctl_d.reg_en = 1'b1;
      end
      // RULE8 - IC capacitor kept charged
      sses_pkg::SSES_RESTART: ctl_d.hv_source_en = 1'b1;
      default: ctl_d.logic_rst = 1'b0;
    endcase
    // RULE12 - pfc stops at once, bridge finishes stroke
    ctl_d.hbc_en = hbc_want || (hbc_run_q && !st_sync[1]);
    // RULE14 - low side held when pin disables bridge
    ctl_d.hbc_low_force = !ctl_d.hbc_en && c.en_pfc == 1'b0 ? 1'b1 :
                          (!ctl_d.hbc_en && !c.en_ic);
    ctl_d.restart_timer_go = (state_d == sses_pkg::SSES_RESTART) &&
                             (state_q != sses_pkg::SSES_RESTART);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl <= '0;
    end else begin
      ctl <= ctl_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sses_pkg::sses_state_t'(`SSES_STATE_RST);
    end else begin
      state <= state_d;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_nosupply_reset: assert property (no_supply |=> ctl.logic_rst && state == sses_pkg::SSES_NO_SUPPLY) // RULE1
    else $error("No supply did not reset");
  chk_disable_pin: assert property (!no_supply && en_off |=> state == sses_pkg::SSES_DISABLED && !ctl.pfc_en) // RULE2
    else $error("Enable low did not disable");
  chk_thermal_hold: assert property ( // RULE3
    state == sses_pkg::SSES_THERMAL |-> !ctl.pfc_en && !ctl.reg_en && !ctl.hv_source_en)
    else $error("Thermal hold outputs wrong");
  chk_icchg_outputs: assert property (state == sses_pkg::SSES_IC_CHARGE |-> ctl.hv_source_en && !ctl.reg_en) // RULE4
    else $error("Supply charge outputs wrong");
  chk_boost_outputs: assert property (state == sses_pkg::SSES_BOOST |-> ctl.pfc_en && !ctl.hv_source_en) // RULE6
    else $error("Boost charge outputs wrong");
  chk_oper_outputs: assert property (state == sses_pkg::SSES_OPER |-> ctl.pfc_en && ctl.hbc_en) // RULE7
    else $error("Operational outputs wrong");
  chk_restart_pulse: assert property ( // RULE8
    $rose(state == sses_pkg::SSES_RESTART) |-> ctl.restart_timer_go ##1 !ctl.restart_timer_go)
    else $error("Restart timer start wrong");
  chk_shutdown_latch: assert property ( // RULE17
    state == sses_pkg::SSES_SHUTDOWN && !c.mains_reset && !en_off && !no_supply
    |=> state == sses_pkg::SSES_SHUTDOWN)
    else $error("Shutdown latch lost");

  cov_reach_oper:  cover property (state == sses_pkg::SSES_BOOST ##[1:50] state == sses_pkg::SSES_OPER);
  cov_restart_run: cover property (state == sses_pkg::SSES_RESTART ##[1:50] state == sses_pkg::SSES_IC_CHARGE);
  cov_shutdown:    cover property (state == sses_pkg::SSES_SHUTDOWN);

endmodule // sses_sequencer
`default_nettype wire

//--- hdl/sses_map.svh
`ifndef SSES_MAP_SVH
`define SSES_MAP_SVH
// Synchroniser depth for comparator inputs
`define SSES_SYNC_STAGES 2
// Number of comparator inputs carried in the input struct
`define SSES_NUM_INPUTS 12
// Reset value of the state register (no supply)
`define SSES_STATE_RST 4'h0
`endif

//--- hdl/sses_pkg.sv
`default_nettype none
package sses_pkg;

  // Operating states
  typedef enum logic [3:0] {
    SSES_NO_SUPPLY  = 4'h0,
    SSES_DISABLED   = 4'h1,
    SSES_THERMAL    = 4'h2,
    SSES_IC_CHARGE  = 4'h3,
    SSES_REG_CHARGE = 4'h4,
    SSES_BOOST      = 4'h5,
    SSES_OPER       = 4'h6,
    SSES_RESTART    = 4'h7,
    SSES_SHUTDOWN   = 4'h8
  } sses_state_t;

  // Comparator results, all active high
  typedef struct packed {
    logic hv_present;        // High-voltage supply above its reset level
    logic ic_present;        // IC supply above its reset level
    logic ic_start;          // IC supply reached start level
    logic reg_start;         // Regulated supply reached start level
    logic reg_uvp;           // Regulated supply below its stop level
    logic ic_uvp;            // IC supply below its stop level
    logic en_pfc;            // Enable pin above pfc_enable_threshold
    logic en_ic;             // Enable pin above whole_ic_enable_threshold
    logic otp;               // Overtemperature active
    logic prot_restart;      // Restart-class protection trigger
    logic prot_shutdown;     // Shutdown-class protection trigger
    logic mains_reset;       // Fast shutdown reset from mains sensing
  } sses_cmp_t;

  // Enables towards the rest of the chip
  typedef struct packed {
    logic pfc_en;            // Power-factor controller switching
    logic hbc_en;            // half_bridge_controller switching
    logic hbc_low_force;     // Hold low-side switch on
    logic hv_source_en;      // High-voltage start-up source
    logic reg_en;            // Series regulator
    logic restart_timer_go;  // Start restart timer
    logic pullup_en;         // enable_pullup_current source
    logic logic_rst;         // Internal logic held in reset
  } sses_ctl_t;

endpackage : sses_pkg
`default_nettype wire

//--- hdl/sses_sync.sv
`default_nettype none
`include "sses_map.svh"
// Two-flop synchroniser, one per bit
module sses_sync #(
  parameter int WIDTH = `SSES_NUM_INPUTS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] d_async,
  output var  logic [WIDTH-1:0] d_sync
);

  logic [WIDTH-1:0] meta_q;

  // First stage is read only by the second stage
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q[gi] <= 1'b0;
          d_sync[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= d_async[gi];
          d_sync[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule // sses_sync
`default_nettype wire

//--- testbench/sses_enable_drive.sv
`default_nettype none
// ----------------------------------------
// Secondary-side circuit on the enable pin
// ----------------------------------------
module sses_enable_drive (
  // Clock and device pull-up
  input  wire logic        clk,
  input  wire logic        pullup_en,
  // Sink command from the opto-coupler
  input  wire logic        sink_on,
  input  wire logic [11:0] sink_mv,
  // Comparator view of the pin
  output var  logic        en_pfc,
  output var  logic        en_ic
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] pin_mv;

  // Pin level in millivolts
  always_comb begin
    if (sink_on) begin
      pin_mv = sink_mv;
    end else if (pullup_en) begin
      pin_mv = 12'hbb8; // Pull-up level
    end else begin
      pin_mv = 12'h000; // Unpowered pin drifts low
    end
  end

  // Comparators settle once per clock, like a slow analogue path
  always_ff @(posedge clk) begin
    en_pfc <= (pin_mv > 12'h4b0);
    en_ic  <= (pin_mv > 12'h898);
  end
endmodule // sses_enable_drive
`default_nettype wire

//--- testbench/supply_state_enable_sequencer_tb_top.sv
`default_nettype none
// ----------------------------------------
// Bench for the supply state sequencer
// ----------------------------------------
module supply_state_enable_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  hb_low_phase = 1'b1;
  logic                  restart_done = 1'b0;
  logic                  sink_on = 1'b0;
  logic [11:0]           sink_mv = 12'h000;
  logic                  en_pfc;
  logic                  en_ic;
  sses_pkg::sses_cmp_t   cmp_q = 12'hc00; // Both supplies present, nothing else
  sses_pkg::sses_cmp_t   cmp_w;
  sses_pkg::sses_ctl_t   ctl;
  sses_pkg::sses_state_t state;
  int                    failures = 0;
  int                    check_count = 0;
  int                    cycles = 0;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  // Pin comparators come from the partner; unknown reads as low
  always_comb begin
    cmp_w = cmp_q;
    cmp_w.en_pfc = (en_pfc === 1'b1);
    cmp_w.en_ic = (en_ic === 1'b1);
  end

  sses_sequencer i_sses_sequencer (.clk(clk), .rst(rst), .cmp_async(cmp_w),
    .hb_low_phase(hb_low_phase), .restart_done(restart_done), .ctl(ctl), .state(state));
  sses_enable_drive i_sses_enable_drive (.clk(clk), .pullup_en(ctl.pullup_en),
    .sink_on(sink_on), .sink_mv(sink_mv), .en_pfc(en_pfc), .en_ic(en_ic));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task stop_test;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Stimulus lands by non-blocking assignment on this edge; reads see what the edge before launched
  task tick;
    @(posedge clk);
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for a state, so a stuck machine cannot hang the run
  task wait_st(input sses_pkg::sses_state_t s);
    int n;
    n = 0;
    while (state !== s && n < 40) begin
      tick;
      n++;
    end
    check(state, s);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // start-up order
  task t_startup;
    sink_on <= 1'b1;
    sink_mv <= 12'h6a4;
    wait_st(sses_pkg::SSES_IC_CHARGE);
    repeat (10) tick;
    check(state, sses_pkg::SSES_IC_CHARGE);
    check({ctl.hv_source_en, ctl.reg_en, ctl.pullup_en}, 3'b101);
    cmp_q.ic_start <= 1'b1;
    wait_st(sses_pkg::SSES_REG_CHARGE);
    repeat (10) tick;
    check(state, sses_pkg::SSES_REG_CHARGE);
    check({ctl.reg_en, ctl.pfc_en}, 2'b10);
    cmp_q.reg_start <= 1'b1;
    wait_st(sses_pkg::SSES_BOOST);
    repeat (10) tick;
    check(state, sses_pkg::SSES_BOOST);
    check({ctl.pfc_en, ctl.hbc_en, ctl.hbc_low_force}, 3'b101);
    sink_on <= 1'b0;
    wait_st(sses_pkg::SSES_OPER);
    check({ctl.pfc_en, ctl.hbc_en}, 2'b11);
    $display("Start-up test done");
  endtask

  task t_enable_low;
    hb_low_phase <= 1'b0;
    sink_on <= 1'b1;
    sink_mv <= 12'h1f4;
    wait_st(sses_pkg::SSES_DISABLED);
    check(ctl.pfc_en, 1'b0);
    repeat (5) tick;
    check(ctl.hbc_en, 1'b1);
    hb_low_phase <= 1'b1;
    repeat (2) tick;
    check({ctl.pfc_en, ctl.hbc_en, ctl.hbc_low_force, ctl.reg_en}, 4'b0010);
    sink_on <= 1'b0;
    wait_st(sses_pkg::SSES_OPER);
    $display("Enable test done");
  endtask

  task t_thermal;
    cmp_q.otp <= 1'b1;
    repeat (3) tick;
    check(state, sses_pkg::SSES_OPER);
    tick;
    check(state, sses_pkg::SSES_THERMAL);
    repeat (10) tick;
    check({ctl.pfc_en, ctl.hbc_en, ctl.hv_source_en, ctl.reg_en}, 4'b0000);
    cmp_q.otp <= 1'b0;
    wait_st(sses_pkg::SSES_OPER);
    $display("Thermal test done");
  endtask

  task t_restart;
    cmp_q.prot_restart <= 1'b1;
    tick;
    cmp_q.prot_restart <= 1'b0;
    wait_st(sses_pkg::SSES_RESTART);
    check({ctl.restart_timer_go, ctl.hv_source_en, ctl.reg_en, ctl.pfc_en, ctl.hbc_en}, 5'b11000);
    tick;
    check(ctl.restart_timer_go, 1'b0);
    repeat (30) tick;
    check(state, sses_pkg::SSES_RESTART);
    restart_done <= 1'b1;
    tick;
    restart_done <= 1'b0;
    wait_st(sses_pkg::SSES_OPER);
    $display("Restart test done");
  endtask

  task t_shutdown;
    int k;
    for (k = 0; k < 2; k++) begin
      cmp_q.prot_shutdown <= 1'b1;
      tick;
      cmp_q.prot_shutdown <= 1'b0;
      wait_st(sses_pkg::SSES_SHUTDOWN);
      check({ctl.pfc_en, ctl.hbc_en, ctl.hv_source_en, ctl.reg_en}, 4'b0000);
      repeat (30) tick;
      check(state, sses_pkg::SSES_SHUTDOWN);
      if (k == 0) begin
        cmp_q.mains_reset <= 1'b1;
        repeat (3) tick;
        cmp_q.mains_reset <= 1'b0;
      end else begin
        sink_on <= 1'b1;
        wait_st(sses_pkg::SSES_DISABLED);
        sink_on <= 1'b0;
      end
      wait_st(sses_pkg::SSES_OPER);
    end
    $display("Shutdown test done");
  endtask

  // pin between thresholds, then a supply dip
  task t_partial;
    sink_mv <= 12'h6a4;
    sink_on <= 1'b1;
    wait_st(sses_pkg::SSES_BOOST);
    check({ctl.pfc_en, ctl.hbc_en, ctl.hbc_low_force}, 3'b101);
    sink_on <= 1'b0;
    wait_st(sses_pkg::SSES_OPER);
    check(ctl.hbc_low_force, 1'b0);
    cmp_q.reg_uvp <= 1'b1;
    tick;
    cmp_q.reg_uvp <= 1'b0;
    wait_st(sses_pkg::SSES_IC_CHARGE);
    check({ctl.pfc_en, ctl.hbc_en, ctl.hv_source_en}, 3'b001);
    wait_st(sses_pkg::SSES_OPER);
    $display("Partial enable test done");
  endtask

  task t_nosupply;
    cmp_q <= 12'h000;
    wait_st(sses_pkg::SSES_NO_SUPPLY);
    check({ctl.logic_rst, ctl.pullup_en, ctl.pfc_en, ctl.hv_source_en}, 4'b1000);
    cmp_q.hv_present <= 1'b1;
    repeat (10) tick;
    check(ctl.pullup_en, 1'b1);
    $display("Supply test done");
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      stop_test;
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_startup;
    t_enable_low;
    t_thermal;
    t_restart;
    t_shutdown;
    t_partial;
    t_nosupply;
    stop_test;
  end
endmodule // supply_state_enable_sequencer_tb_top
`default_nettype wire
